/* src/dual_bus_mailbox_io.sv */
// local bus master, system bus mailbox slave and halt logic of the signal processor
//
// Overview of operation
// - local data bus joined 16-bit or split bytes
// - 4-bit local address, 12 with system lines
// - split bus: low lane only for 00
// - high lane stays ours while low is lent
// - programmable slow exchange lengthens local transfers
// - fast one 160 ns cycle, slow two, repeated
// - strobe plus direction, or read/write pulses
// - style 0 read/write pulses, 1 strobe
// - role 1 lends system lines as addresses
// - inbound three byte stages, read to left
// - inbound shifts on master write, slave read
// - outbound three byte stages from result bus
// - outbound shifts on master read, slave write
// - owner flag: 0 slave, 1 master
// - slave sets owner flag, master release clears
// - owner flag testable and settable by software
// - handshake asserted together with owner flag set
// - location 00 access negates the handshake
// - location 01 access clears the owner flag
// - two locations decoded from select inputs only
// - halt stops after current transfer, freezes counters
// - halt issues no-ops, no system addresses
// - bus available shows system lines unused
// - transfer acknowledge output for master bus cycles
`timescale 1ns/1ps
`include "dual_bus_mailbox_io_regs.svh"
module dual_bus_mailbox_io
  import dual_bus_mailbox_io_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 nrst,
  input  wire logic                 exchange_speed_select,
  input  wire logic                 address_lending_mode,
  input  wire logic                 bus_joined,
  input  wire logic                 strobe_style,
  input  wire logic                 halt_req,
  output logic                      halted,
  output logic                      counters_frozen,
  output logic                      nop_issue,
  input  wire logic                 lreq_valid,
  output logic                      lreq_ready,
  input  wire logic                 lreq_write,
  input  wire logic [`LOCAL_AW-1:0] lreq_addr,
  input  wire logic [`LOCAL_DW-1:0] lreq_wdata,
  output logic                      lresp_done,
  output logic [`LOCAL_DW-1:0]      lresp_rdata,
  output logic                      instr_repeat,
  output logic [3:0]                local_addr,
  input  wire logic [`LOCAL_DW-1:0] local_data_in,
  output logic [`LOCAL_DW-1:0]      local_data_out,
  output logic                      local_data_oe_lo,
  output logic                      local_data_oe_hi,
  output logic                      local_rd_n,
  output logic                      local_wr_n,
  output logic                      local_data_strobe_n,
  output logic                      local_read,
  input  wire logic [`BYTE_W-1:0]   sys_ad_in,
  output logic [`BYTE_W-1:0]        sys_ad_out,
  output logic                      sys_ad_oe,
  input  wire logic                 chip_select_n,
  input  wire logic                 register_select,
  input  wire logic                 system_direction,
  input  wire logic                 system_strobe_n,
  output logic                      handshake_n,
  output logic                      transfer_acknowledge_n,
  output logic                      bus_available,
  input  wire logic                 inbound_read,
  output logic [`BYTE_W-1:0]        left_bus_hi,
  input  wire logic                 outbound_write,
  input  wire logic [`BYTE_W-1:0]   result_hi,
  input  wire logic                 owner_set,
  output logic                      mailbox_owner_flag
);
  localparam int FAST_D = `FAST_CYC;
  localparam int SLOW_D = `SLOW_CYC;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [3:0]                ctl_s1;
  logic [3:0]                ctl_s2;
  logic [`BYTE_W-1:0]        ad_s1;
  logic [`BYTE_W-1:0]        ad_s2;
  logic [`LOCAL_DW-1:0]      ld_s1;
  logic [`LOCAL_DW-1:0]      ld_s2;
  logic                      strobe_prev;
  logic                      cs_n_s;
  logic                      rs_s;
  logic                      dir_s;
  logic                      strobe_n_s;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctl_s1 <= `SYS_CTL_IDLE;
      ctl_s2 <= `SYS_CTL_IDLE;
      ad_s1  <= '0;
      ad_s2  <= '0;
      ld_s1  <= '0;
      ld_s2  <= '0;
    end else begin
      ctl_s1 <= {chip_select_n, register_select, system_direction, system_strobe_n};
      ctl_s2 <= ctl_s1;
      ad_s1  <= sys_ad_in;
      ad_s2  <= ad_s1;
      ld_s1  <= local_data_in;
      ld_s2  <= ld_s1;
    end
  end

  assign {cs_n_s, rs_s, dir_s, strobe_n_s} = ctl_s2;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      strobe_prev <= 1'b1;
    end else begin
      strobe_prev <= strobe_n_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // master access decode

  logic acc_ok;
  logic mbx_access;
  logic release_access;
  logic master_wr;
  logic master_rd;
  logic master_holds;
  logic handshake_active;
  logic ack_active;
  logic sys_rd_active;

  // master drives direction and strobe; only accesses while it owns the mailbox count
  assign acc_ok = strobe_prev && !strobe_n_s && !cs_n_s && mailbox_owner_flag;
  assign mbx_access     = acc_ok && (rs_s == `LOC_ACCESS);
  assign release_access = acc_ok && (rs_s == `LOC_RELEASE);
  assign master_wr      = mbx_access && !dir_s;
  assign master_rd      = mbx_access && dir_s;

  // set by the slave only, cleared by the release only; set wins
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mailbox_owner_flag <= 1'b0;
    end else if (owner_set) begin
      mailbox_owner_flag <= 1'b1;
    end else if (release_access) begin
      mailbox_owner_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      handshake_active <= 1'b0;
    end else if (owner_set) begin
      handshake_active <= 1'b1;
    end else if (mbx_access) begin
      handshake_active <= 1'b0;
    end
  end

  assign handshake_n = !handshake_active;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      master_holds <= 1'b0;
    end else if (release_access) begin
      master_holds <= 1'b0;
    end else if (mbx_access && address_lending_mode) begin
      master_holds <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ack_active <= 1'b0;
    end else if (acc_ok) begin
      ack_active <= 1'b1;
    end else if (strobe_n_s) begin
      ack_active <= 1'b0;
    end
  end

  assign transfer_acknowledge_n = !ack_active;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sys_rd_active <= 1'b0;
    end else if (master_rd) begin
      sys_rd_active <= 1'b1;
    end else if (strobe_n_s) begin
      sys_rd_active <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // mailbox shift registers

  logic [`MBX_DEPTH-1:0][`BYTE_W-1:0] inbound_mailbox;
  logic [`MBX_DEPTH-1:0][`BYTE_W-1:0] outbound_mailbox;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      inbound_mailbox <= '0;
    end else if (master_wr) begin
      inbound_mailbox <= {inbound_mailbox[`MBX_DEPTH-2:0], ad_s2};
    end else if (inbound_read) begin
      inbound_mailbox <= {inbound_mailbox[`MBX_DEPTH-2:0], `BYTE_ZERO};
    end
  end

  assign left_bus_hi = inbound_mailbox[`MBX_DEPTH-1];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      outbound_mailbox <= '0;
    end else if (master_rd) begin
      outbound_mailbox <= {outbound_mailbox[`MBX_DEPTH-2:0], `BYTE_ZERO};
    end else if (outbound_write) begin
      outbound_mailbox <= {outbound_mailbox[`MBX_DEPTH-2:0], result_hi};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // local request queue

  data_stream_if #(.W($bits(lreq_t))) req_in ();
  data_stream_if #(.W($bits(lreq_t))) req_out ();

  assign req_in.valid = lreq_valid;
  assign req_in.data  = {lreq_write, lreq_addr, lreq_wdata};
  assign lreq_ready   = req_in.ready;

  req_fifo #(
    .W     ($bits(lreq_t)),
    .DEPTH (`REQ_FIFO_DEPTH)
  ) u_req_fifo (
    .clock (clock),
    .nrst  (nrst),
    .fill  (req_in),
    .drain (req_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // local bus sequencer

  seq_state_t state;
  lreq_t      head;
  lreq_t      cur;
  cnt_t       count;
  logic       cur_joined;
  logic       cur_style;
  logic       cur_slow;
  logic       lane_hi;
  logic       pop;
  logic       using_sys;
  logic       in_access;

  assign head          = lreq_t'(req_out.data);
  // halt: finish the running transfer, start nothing new
  assign req_out.ready = (state == SEQ_IDLE) && !halt_req && !halted;
  assign pop           = req_out.valid && req_out.ready;
  assign in_access     = state == SEQ_ACCESS;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= SEQ_IDLE;
      count <= '0;
    end else begin
      case (state)
        SEQ_IDLE: begin
          if (pop) begin
            state <= SEQ_ACCESS;
            if (exchange_speed_select == `SPEED_SLOW) begin
              count <= cnt_t'(`SLOW_CYC - 1);
            end else begin
              count <= cnt_t'(`FAST_CYC - 1);
            end
          end
        end
        SEQ_ACCESS: begin
          if (count == '0) begin
            state <= SEQ_IDLE;
          end else begin
            count <= count - 1'b1;
          end
        end
        default: begin
          state <= SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cur        <= '0;
      cur_joined <= 1'b1;
      cur_style  <= `STYLE_RDWR;
      cur_slow   <= 1'b0;
      lane_hi    <= 1'b0;
    end else if (pop) begin
      cur        <= head;
      cur_joined <= bus_joined;
      cur_style  <= strobe_style;
      cur_slow   <= exchange_speed_select == `SPEED_SLOW;
      lane_hi    <= head.addr[`LANE_SEL_HI:`LANE_SEL_LO] != `LANE_LO_CODE;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      local_addr     <= '0;
      local_data_out <= '0;
    end else if (pop) begin
      local_addr <= head.addr[`LOCAL_AW-1:`PIN_ADDR_LO];
      if (bus_joined) begin
        local_data_out <= head.data;
      end else begin
        local_data_out <= {head.data[`BYTE_W-1:0], head.data[`BYTE_W-1:0]};
      end
    end
  end

  // split bus: a high lane transfer never touches the low lane
  assign local_data_oe_lo = in_access && cur.write && (cur_joined || !lane_hi);
  assign local_data_oe_hi = in_access && cur.write && (cur_joined || lane_hi);

  assign local_rd_n = !(in_access && cur_style == `STYLE_RDWR && !cur.write);
  assign local_wr_n = !(in_access && cur_style == `STYLE_RDWR && cur.write);
  assign local_data_strobe_n = !(in_access && cur_style == `STYLE_STROBE);
  assign local_read = !(in_access && cur.write);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lresp_done   <= 1'b0;
      lresp_rdata  <= '0;
      instr_repeat <= 1'b0;
    end else begin
      lresp_done   <= in_access && count == '0;
      // slow exchange re-issues the defining instruction halfway through
      instr_repeat <= in_access && cur_slow && count == cnt_t'(`FAST_CYC);
      if (in_access && count == '0 && !cur.write) begin
        if (cur_joined) begin
          lresp_rdata <= ld_s2;
        end else if (lane_hi) begin
          lresp_rdata <= {`BYTE_ZERO, ld_s2[`LOCAL_DW-1:`BYTE_W]};
        end else begin
          lresp_rdata <= {`BYTE_ZERO, ld_s2[`BYTE_W-1:0]};
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // halt and system bus address lending

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      halted <= 1'b0;
    end else if (!halt_req) begin
      halted <= 1'b0;
    end else if (state == SEQ_IDLE) begin
      halted <= 1'b1;
    end
  end

  assign counters_frozen = halted;
  assign nop_issue       = halted;

  assign using_sys     = address_lending_mode && !master_holds && !halted;
  assign bus_available = !using_sys;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sys_ad_out <= '0;
    end else if (master_rd) begin
      sys_ad_out <= outbound_mailbox[`MBX_DEPTH-1];
    end else if (pop) begin
      sys_ad_out <= head.addr[`PIN_ADDR_LO-1:0];
    end
  end

  assign sys_ad_oe = sys_rd_active || (using_sys && in_access);

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence s_fast_pop;
    pop && exchange_speed_select != `SPEED_SLOW;
  endsequence

  sequence s_slow_pop;
    pop && exchange_speed_select == `SPEED_SLOW;
  endsequence

  property p_fast_len;
    s_fast_pop |=> !lresp_done [*2] ##(FAST_D - 1) lresp_done;
  endproperty
  a_fast_len: assert property (p_fast_len) else $error("fast exchange length wrong");

  property p_slow_len;
    s_slow_pop |=> ##FAST_D instr_repeat ##(SLOW_D - FAST_D) lresp_done;
  endproperty
  a_slow_len: assert property (p_slow_len) else $error("slow exchange length wrong");

  property p_lane_split;
    in_access && !cur_joined && cur.addr[`LANE_SEL_HI:`LANE_SEL_LO] != `LANE_LO_CODE
      |-> !local_data_oe_lo;
  endproperty
  a_lane_split: assert property (p_lane_split) else $error("low lane driven");

  property p_style;
    in_access && cur_style == `STYLE_STROBE |-> !local_data_strobe_n && local_rd_n && local_wr_n;
  endproperty
  a_style: assert property (p_style) else $error("strobe style wrong");

  property p_handshake;
    owner_set |=> mailbox_owner_flag && !handshake_n;
  endproperty
  a_handshake: assert property (p_handshake) else $error("handshake not raised");

  property p_negate;
    mbx_access && !owner_set |=> handshake_n;
  endproperty
  a_negate: assert property (p_negate) else $error("handshake not negated");

  property p_release;
    release_access && !owner_set |=> !mailbox_owner_flag && !master_holds;
  endproperty
  a_release: assert property (p_release) else $error("release ignored");

  property p_inbound;
    master_wr |=> inbound_mailbox[0] == $past(ad_s2)
      && inbound_mailbox[1] == $past(inbound_mailbox[0]);
  endproperty
  a_inbound: assert property (p_inbound) else $error("inbound shift wrong");

  property p_halt;
    halted |-> bus_available && !(in_access || pop);
  endproperty
  a_halt: assert property (p_halt) else $error("halt still active on bus");

  property p_ack;
    acc_ok |=> !transfer_acknowledge_n;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge missing");
endmodule

/* src/dual_bus_mailbox_io_regs.svh */
// named constants for the dual bus mailbox sequencer
`ifndef DUAL_BUS_MAILBOX_IO_REGS_SVH
`define DUAL_BUS_MAILBOX_IO_REGS_SVH
`define CLK_PERIOD_NS  25
`define FAST_XFER_NS   160
`define FAST_CYC       ((`FAST_XFER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLOW_CYC       (2 * `FAST_CYC)
`define CNT_W          4
`define MBX_DEPTH      3
`define REQ_FIFO_DEPTH 8
`define LOCAL_AW       12
`define LOCAL_DW       16
`define BYTE_W         8
`define PIN_ADDR_LO    8
`define LANE_SEL_HI    11
`define LANE_SEL_LO    10
`define LANE_LO_CODE   2'h0
`define LOC_ACCESS     1'h0
`define LOC_RELEASE    1'h1
`define STYLE_RDWR     1'h0
`define STYLE_STROBE   1'h1
`define SPEED_SLOW     1'h1
`define SYS_CTL_IDLE   4'hb
`define BYTE_ZERO      8'h00
`endif

/* src/dual_bus_mailbox_io_pkg.sv */
// types shared by the dual bus mailbox sequencer
`include "dual_bus_mailbox_io_regs.svh"
package dual_bus_mailbox_io_pkg;
  typedef enum {SEQ_IDLE, SEQ_ACCESS} seq_state_t;
  typedef logic [`CNT_W-1:0] cnt_t;
  typedef struct packed {
    logic                    write;
    logic [`LOCAL_AW-1:0]    addr;
    logic [`LOCAL_DW-1:0]    data;
  } lreq_t;
endpackage

/* src/data_stream_if.sv */
// valid/ready word stream between the sequencer and its request queue
`timescale 1ns/1ps
interface data_stream_if #(parameter int W = 8) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport sink   (input valid, input data, output ready);
  modport source (output valid, output data, input ready);
endinterface

/* src/req_fifo.sv */
// request queue with valid/ready on both sides
`timescale 1ns/1ps
module req_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic   clock,
  input  wire logic   nrst,
  data_stream_if.sink   fill,
  data_stream_if.source drain
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic         full;
  logic         empty;

  // extra pointer bit tells full from empty; depth must be a power of two
  assign empty       = wr_ptr == rd_ptr;
  assign full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign fill.ready  = !full;
  assign drain.valid = !empty;
  assign drain.data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clock) begin
    if (fill.valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= fill.data;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
    end else if (fill.valid && !full) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_ptr <= '0;
    end else if (drain.ready && !empty) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

/* tb/sys_master_model.sv */
// behavioural external master on the system bus of the mailbox sequencer
`timescale 1ns/1ps
module sys_master_model (
  input  wire logic       clock,
  input  wire logic       ack_n,
  input  wire logic [7:0] ad_wire,
  output logic            cs_n,
  output logic            rs,
  output logic            dir,
  output logic            strobe_n,
  output logic [7:0]      ad_drive
);
  initial begin
    cs_n     = 1'b1;
    rs       = 1'b0;
    dir      = 1'b1;
    strobe_n = 1'b1;
    ad_drive = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // strobe stays put until acknowledge is sampled low, select until it is sampled high again
  task automatic access(input logic rs_v, dir_v, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic ok);
    int i;
    ok = 1'b0;
    @(posedge clock);
    cs_n     <= 1'b0;
    rs       <= rs_v;
    dir      <= dir_v;
    strobe_n <= 1'b0;
    if (!dir_v) begin
      ad_drive <= wdata;
    end
    for (i = 0; i < 20 && !ok; i++) begin
      @(posedge clock);
      ok = (ack_n === 1'b0);
    end
    rdata = ad_wire;
    strobe_n <= 1'b1;
    for (i = 0; i < 20 && ack_n !== 1'b1; i++) begin
      @(posedge clock);
    end
    ok = ok && (ack_n === 1'b1);
    cs_n <= 1'b1;
    // released lines show the inverse of their last level
    ad_drive <= ~ad_wire;
  endtask
endmodule

/* tb/tb.sv */
// self-checking bench for the dual bus mailbox sequencer
`timescale 1ns/1ps
`include "dual_bus_mailbox_io_regs.svh"
module tb;
  logic                 clock, nrst, exchange_speed_select, address_lending_mode, bus_joined;
  logic                 strobe_style, halt_req, halted, counters_frozen, nop_issue;
  logic                 lreq_valid, lreq_ready, lreq_write, lresp_done, instr_repeat;
  logic [`LOCAL_AW-1:0] lreq_addr;
  logic [`LOCAL_DW-1:0] lreq_wdata, lresp_rdata, local_data_in, local_data_out;
  logic [3:0]           local_addr;
  logic                 local_data_oe_lo, local_data_oe_hi, local_rd_n, local_wr_n;
  logic                 local_data_strobe_n, local_read, sys_ad_oe, chip_select_n;
  logic                 register_select, system_direction, system_strobe_n, handshake_n;
  logic                 transfer_acknowledge_n, bus_available, inbound_read;
  logic                 outbound_write, owner_set, mailbox_owner_flag;
  logic [`BYTE_W-1:0]   sys_ad_in, sys_ad_out, master_drive, left_bus_hi, result_hi;
  int                   bad_count, n_compared, k, d;

  assign local_data_in = {local_data_oe_hi ? local_data_out[15:8] : 8'ha5,
                          local_data_oe_lo ? local_data_out[7:0] : 8'h5a};
  assign sys_ad_in = sys_ad_oe ? sys_ad_out : master_drive;

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  dual_bus_mailbox_io dual_bus_mailbox_io_inst (.*);

  sys_master_model sys_master_model_inst (
    .clock    (clock),
    .ack_n    (transfer_acknowledge_n),
    .ad_wire  (sys_ad_in),
    .cs_n     (chip_select_n),
    .rs       (register_select),
    .dir      (system_direction),
    .strobe_n (system_strobe_n),
    .ad_drive (master_drive)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // one local transfer; cfg is {slow, joined, strobe style}
  task automatic xfer(input logic [2:0] cfg, input logic wr, lend, input logic [11:0] adr);
    logic        lo, hi;
    logic [15:0] wd;
    int          n;
    lo = cfg[1] | (adr[11:10] == `LANE_LO_CODE);
    hi = cfg[1] | (adr[11:10] != `LANE_LO_CODE);
    wd = {4'h3, adr};
    n = 0;
    @(posedge clock);
    {exchange_speed_select, bus_joined, strobe_style} <= cfg;
    {lreq_valid, lreq_write, lreq_addr, lreq_wdata} <= {1'b1, wr, adr, wd};
    @(posedge clock);
    lreq_valid <= 1'b0;
    while (lresp_done !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
      if (n == 2) begin
        check("rd_n", cfg[0] | wr, local_rd_n);
        check("wr_n", cfg[0] | !wr, local_wr_n);
        check("ds_n", !cfg[0], local_data_strobe_n);
        check("read", !wr, local_read);
        check("oe", {wr & hi, wr & lo}, {local_data_oe_hi, local_data_oe_lo});
        check("addr", adr[11:8], local_addr);
        check("sys_ad", lend ? {1'b1, adr[7:0]} : 9'h000,
              {sys_ad_oe, sys_ad_oe ? sys_ad_out : 8'h00});
        check("ba", !lend, bus_available);
        if (wr) check("dout", cfg[1] ? wd : {2{wd[7:0]}}, local_data_out);
      end
      if (cfg[2] && n == 1 + `FAST_CYC) check("repeat", 1, instr_repeat);
    end
    check("cycles", cfg[2] ? 1 + `SLOW_CYC : 1 + `FAST_CYC, 16'(n));
    if (n == 40) report_and_stop();
    if (!wr) check("rdata", cfg[1] ? 16'ha55a : (lo ? 16'h005a : 16'h00a5), lresp_rdata);
  endtask

  task automatic mbx(input logic rs_v, dir_v, input logic [7:0] wd, input logic exp_ok,
                     input logic [7:0] exp_rd);
    logic [7:0] rd;
    logic       ok;
    sys_master_model_inst.access(rs_v, dir_v, wd, rd, ok);
    check("ack", exp_ok, ok);
    if (ok !== exp_ok) report_and_stop();
    if (dir_v && exp_ok && !rs_v) check("sys_rd", exp_rd, rd);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {exchange_speed_select, address_lending_mode, bus_joined, strobe_style} = 4'h0;
    {halt_req, lreq_valid, lreq_write, inbound_read, outbound_write, owner_set} = 6'h00;
    {lreq_addr, lreq_wdata, result_hi} = '0;
    bad_count = 0;
    n_compared = 0;
    nrst = 1'b0;
    repeat (10) @(posedge clock);
    #1;
    check("rst", 5'b11010, {handshake_n, transfer_acknowledge_n, mailbox_owner_flag,
                            bus_available, halted});
    check("rst_left", 0, left_bus_hi);
    nrst <= 1'b1;
    for (k = 0; k < 8; k++) xfer(k[2:0], k[0] ^ k[1], 1'b0, {k[2:0], 9'h0a5});
    // halt: nothing is popped, the queue fills until it refuses, then drains
    @(posedge clock);
    {halt_req, address_lending_mode, exchange_speed_select, lreq_valid, lreq_write} <= 5'b11011;
    k = 0;
    d = 0;
    repeat (14) begin
      @(posedge clock);
      k += (lreq_ready === 1'b1);
      d += (lresp_done === 1'b1);
    end
    lreq_valid <= 1'b0;
    #1;
    check("queued", `REQ_FIFO_DEPTH, 16'(k));
    check("full", 0, lreq_ready);
    check("halt", 4'b1110, {halted, counters_frozen, nop_issue, 1'(d)});
    check("halt_sys", 0, sys_ad_oe);
    @(posedge clock);
    halt_req <= 1'b0;
    d = 0;
    repeat (100) begin
      @(posedge clock);
      d += (lresp_done === 1'b1);
    end
    check("drained", `REQ_FIFO_DEPTH, 16'(d));
    check("resumed", 0, halted);
    // mailbox exchange with a lending device
    for (k = 0; k < 3; k++) begin
      @(posedge clock);
      {outbound_write, result_hi} <= {1'b1, 8'(8'h11 * (k + 1))};
    end
    @(posedge clock);
    outbound_write <= 1'b0;
    xfer(3'b000, 1'b1, 1'b1, 12'h4c3);
    mbx(1'b0, 1'b1, 8'h00, 1'b0, 8'h00);
    @(posedge clock);
    owner_set <= 1'b1;
    @(posedge clock);
    owner_set <= 1'b0;
    #1;
    check("flag", 2'b10, {mailbox_owner_flag, handshake_n});
    mbx(1'b0, 1'b1, 8'h00, 1'b1, 8'h11);
    check("hs_off", 1, handshake_n);
    check("ba_held", 1, bus_available);
    xfer(3'b010, 1'b0, 1'b0, 12'h0c3);
    mbx(1'b0, 1'b1, 8'h00, 1'b1, 8'h22);
    mbx(1'b0, 1'b1, 8'h00, 1'b1, 8'h33);
    for (k = 4; k < 7; k++) mbx(1'b0, 1'b0, 8'(8'h11 * k), 1'b1, 8'h00);
    check("left", 8'h44, left_bus_hi);
    @(posedge clock);
    inbound_read <= 1'b1;
    @(posedge clock);
    inbound_read <= 1'b0;
    #1;
    check("left_next", 8'h55, left_bus_hi);
    mbx(1'b1, 1'b1, 8'h00, 1'b1, 8'h00);
    check("released", 2'b00, {mailbox_owner_flag, bus_available});
    mbx(1'b0, 1'b1, 8'h00, 1'b0, 8'h00);
    report_and_stop();
  end
endmodule
